// File: logic/srs_pkg.sv
`default_nettype none
package srs_pkg;
	localparam logic [1:0] SRS_LEVEL_LOWEST = 2'h0;
	localparam int SRS_LEVELS = 4;
	// boot sequence length after brownout release
	localparam int SRS_BOOT_NS = 1000;
	localparam int SRS_CLK_MHZ = 125;
	localparam int SRS_BOOT_CYCLES = (SRS_BOOT_NS * SRS_CLK_MHZ + 999) / 1000;
	localparam logic [7:0] SRS_CNT_ZERO = 8'h00;
	localparam logic [7:0] SRS_CNT_ONE = 8'h01;

	typedef enum {
		SRS_ST_POR,
		SRS_ST_BOR,
		SRS_ST_BOOT,
		SRS_ST_RUN
	} srs_state_type;

	typedef struct packed {
		logic power_on_hold;
		logic brownout_hold;
		logic boot_level_reset;
		logic system_level_reset;
		logic core_level_reset;
	} srs_resets_type;
endpackage
`default_nettype wire

// File: logic/srs_sequencer.sv
// How it works
// - above upper power-on level, leave hold, enable monitor
// - above lowest threshold, boot proceeds, power unit starts
// - below lowest threshold, hold in brownout
// - higher threshold trip: interrupt, fall back lowest
// - four threshold levels, lowest during startup
// - software may raise threshold after boot
// - five reset levels provided
// - clock domain reset by upper three only
`default_nettype none
module srs_sequencer
	import srs_pkg::*;
#(
	parameter int BOOT_CYCLES = srs_pkg::SRS_BOOT_CYCLES
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic supply_above_por,
	input wire logic supply_above_lowest_brownout_threshold,
	input wire logic supply_above_sel,
	input wire logic sw_level_write,
	input wire logic [1:0] sw_level,
	input wire logic sys_reset_req,
	input wire logic core_reset_req,
	output srs_pkg::srs_resets_type resets,
	output logic rtc_reset,
	output logic bandgap_monitor_enable,
	output logic power_management_unit_enable,
	output logic [1:0] active_level,
	output logic brownout_irq
);
	import srs_pkg::*;

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic [2:0] sync1_reg;
	logic [2:0] sync2_reg;
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			sync1_reg <= 3'h0;
			sync2_reg <= 3'h0;
		end else begin
			sync1_reg <= {supply_above_sel, supply_above_lowest_brownout_threshold,
				supply_above_por};
			sync2_reg <= sync1_reg;
		end
	end
	logic por_ok;
	logic lowest_ok;
	logic sel_ok;
	assign por_ok = sync2_reg[0];
	assign lowest_ok = sync2_reg[1];
	assign sel_ok = sync2_reg[2];

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	srs_state_type state_reg;
	logic [7:0] boot_cnt_reg;
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state_reg <= SRS_ST_POR;
			boot_cnt_reg <= SRS_CNT_ZERO;
		end else if (!por_ok) begin
			state_reg <= SRS_ST_POR;
			boot_cnt_reg <= SRS_CNT_ZERO;
		end else begin
			unique case (state_reg)
				SRS_ST_POR: begin
					state_reg <= SRS_ST_BOR;
				end
				SRS_ST_BOR: begin
					if (lowest_ok) begin
						state_reg <= SRS_ST_BOOT;
						boot_cnt_reg <= 8'(BOOT_CYCLES);
					end
				end
				SRS_ST_BOOT: begin
					if (!lowest_ok)
						state_reg <= SRS_ST_BOR;
					else if (boot_cnt_reg <= SRS_CNT_ONE)
						state_reg <= SRS_ST_RUN;
					else
						boot_cnt_reg <= boot_cnt_reg - SRS_CNT_ONE;
				end
				SRS_ST_RUN: begin
					if (!lowest_ok)
						state_reg <= SRS_ST_BOR;
				end
			endcase
		end
	end

	// ----------------------------------------
	// threshold selection
	// ----------------------------------------
	logic high_trip;
	assign high_trip = (state_reg == SRS_ST_RUN) && (active_level != SRS_LEVEL_LOWEST) && !sel_ok;
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			active_level <= SRS_LEVEL_LOWEST;
		end else if ((state_reg != SRS_ST_RUN) || !por_ok) begin
			// supply loss drops level in the same cycle that boot reset rises
			// lowest level during startup
			active_level <= SRS_LEVEL_LOWEST;
		end else if (high_trip) begin
			// fall back to lowest, trip wins
			active_level <= SRS_LEVEL_LOWEST;
		end else if (sw_level_write) begin
			active_level <= sw_level;
		end
	end
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset)
			brownout_irq <= 1'b0;
		else
			brownout_irq <= high_trip;
	end

	// ----------------------------------------
	// reset distribution
	// ----------------------------------------
	srs_resets_type res_next;
	always_comb begin
		res_next.power_on_hold = (state_reg == SRS_ST_POR) || !por_ok;
		res_next.brownout_hold = res_next.power_on_hold || (state_reg == SRS_ST_BOR);
		res_next.boot_level_reset = res_next.brownout_hold || (state_reg == SRS_ST_BOOT);
		res_next.system_level_reset = res_next.boot_level_reset || sys_reset_req;
		res_next.core_level_reset = res_next.system_level_reset || core_reset_req;
	end
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			resets <= '1;
			rtc_reset <= 1'b1;
			bandgap_monitor_enable <= 1'b0;
			power_management_unit_enable <= 1'b0;
		end else begin
			resets <= res_next;
			rtc_reset <= res_next.boot_level_reset;
			bandgap_monitor_enable <= !res_next.power_on_hold;
			power_management_unit_enable <= !res_next.brownout_hold;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_nest;
		@(posedge ref_clk) disable iff (reset)
		resets.power_on_hold |-> resets.brownout_hold && resets.boot_level_reset
			&& resets.system_level_reset && resets.core_level_reset;
	endproperty
	a_nest: assert property (p_nest) else $error("reset nesting broken");

	property p_rtc;
		@(posedge ref_clk) disable iff (reset)
		rtc_reset == resets.boot_level_reset;
	endproperty
	a_rtc: assert property (p_rtc) else $error("rtc reset mismatch");

	property p_fallback;
		@(posedge ref_clk) disable iff (reset)
		high_trip |=> active_level == SRS_LEVEL_LOWEST && brownout_irq;
	endproperty
	a_fallback: assert property (p_fallback) else $error("no fallback on trip");

	property p_startup_low;
		@(posedge ref_clk) disable iff (reset)
		resets.boot_level_reset |-> active_level == SRS_LEVEL_LOWEST;
	endproperty
	a_startup_low: assert property (p_startup_low) else $error("level not lowest");

	property p_bor_hold;
		@(posedge ref_clk) disable iff (reset)
		(por_ok && !lowest_ok && state_reg == SRS_ST_RUN) |=> ##1 resets.brownout_hold;
	endproperty
	a_bor_hold: assert property (p_bor_hold) else $error("no brownout hold");

	property p_power_unit;
		@(posedge ref_clk) disable iff (reset)
		power_management_unit_enable |-> !resets.brownout_hold && bandgap_monitor_enable;
	endproperty
	a_power_unit: assert property (p_power_unit) else $error("power unit on during hold");

	property p_boot_done;
		@(posedge ref_clk) disable iff (reset)
		(state_reg == SRS_ST_BOOT && por_ok && lowest_ok && boot_cnt_reg <= SRS_CNT_ONE)
			##1 por_ok |=> power_management_unit_enable;
	endproperty
	a_boot_done: assert property (p_boot_done) else $error("power unit not started");

	property p_por_release;
		@(posedge ref_clk) disable iff (reset)
		(state_reg == SRS_ST_POR && por_ok) ##1 por_ok |=> bandgap_monitor_enable;
	endproperty
	a_por_release: assert property (p_por_release) else $error("monitor not enabled");

	property p_sw_level;
		@(posedge ref_clk) disable iff (reset)
		(state_reg == SRS_ST_RUN && por_ok && !high_trip && sw_level_write)
			|=> active_level == $past(sw_level);
	endproperty
	a_sw_level: assert property (p_sw_level) else $error("level not written");

	// the fallback removes the trip cause, so the request lasts one cycle
	property p_irq_single;
		@(posedge ref_clk) disable iff (reset)
		brownout_irq |=> !brownout_irq;
	endproperty
	a_irq_single: assert property (p_irq_single) else $error("interrupt held too long");
endmodule
`default_nettype wire

// File: bench/srs_supply_model.sv
`default_nettype none
module srs_supply_model #(
	parameter logic [7:0] POR_TRIP = 8'h10,
	parameter logic [7:0] LOWEST_TRIP = 8'h20
) (
	input wire logic [7:0] supply,
	input wire logic [1:0] level,
	output logic above_por,
	output logic above_lowest,
	output logic above_sel
);
	// ideal comparators, no hysteresis; each level 8'h10 above the last
	assign above_por = supply > POR_TRIP;
	assign above_lowest = supply > LOWEST_TRIP;
	assign above_sel = supply > (LOWEST_TRIP + {2'h0, level, 4'h0});
endmodule
`default_nettype wire

// File: bench/srs_sequencer_tb.sv
`default_nettype none
module srs_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import srs_pkg::*;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] supply = 8'h00;
	logic sw_level_write = 1'b0;
	logic [1:0] sw_level = 2'h0;
	logic sys_req = 1'b0;
	logic core_req = 1'b0;
	logic a_por, a_lowest, a_sel, rtc, bg, pu, irq, seen;
	logic [1:0] level;
	srs_resets_type resets;
	int miscompares = 0;
	int check_count = 0;
	int cycles = 0;
	always #4 ref_clk = ~ref_clk;
	srs_supply_model model_u (.supply(supply), .level(level), .above_por(a_por),
		.above_lowest(a_lowest), .above_sel(a_sel));
	srs_sequencer #(.BOOT_CYCLES(2)) dut_u (.ref_clk(ref_clk), .reset(reset),
		.supply_above_por(a_por), .supply_above_lowest_brownout_threshold(a_lowest),
		.supply_above_sel(a_sel),
		.sw_level_write(sw_level_write), .sw_level(sw_level), .sys_reset_req(sys_req),
		.core_reset_req(core_req), .resets(resets), .rtc_reset(rtc),
		.bandgap_monitor_enable(bg), .power_management_unit_enable(pu),
		.active_level(level), .brownout_irq(irq));
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic look(input logic [4:0] r, input logic [2:0] f);
		chk("resets", {3'h0, r}, {3'h0, resets});
		chk("rtc_bg_pu", {5'h00, f}, {5'h00, rtc, bg, pu});
	endtask
	task automatic t_supply(input logic [7:0] v, input logic [4:0] r, input logic [2:0] f);
		supply = v;
		step(10);
		look(r, f);
	endtask
	task automatic t_req;
		sys_req = 1'b1;
		step(4);
		look(5'h03, 3'b011);
		sys_req = 1'b0;
		core_req = 1'b1;
		step(4);
		look(5'h01, 3'b011);
		core_req = 1'b0;
		step(4);
	endtask
	task automatic t_refuse;
		sw_level = 2'h3;
		sw_level_write = 1'b1;
		step(1);
		sw_level_write = 1'b0;
		step(1);
		chk("level_held", 8'h00, {6'h00, level});
	endtask
	task automatic t_trip(input logic [1:0] lvl, input logic [7:0] low_v);
		supply = 8'h80;
		step(4);
		sw_level = lvl;
		sw_level_write = 1'b1;
		step(1);
		sw_level_write = 1'b0;
		step(1);
		chk("level_raised", {6'h00, lvl}, {6'h00, level});
		supply = low_v;
		seen = 1'b0;
		repeat (8) begin
			step(1);
			seen = seen | irq;
		end
		chk("irq_seen", 8'h01, {7'h00, seen});
		chk("level_fallback", 8'h00, {6'h00, level});
		look(5'h00, 3'b011);
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// hang guard: whole run needs well under 300 cycles
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			miscompares++;
			wrap_up();
		end
	end
	initial begin
		step(5);
		look(5'h1F, 3'b100);
		chk("level_reset", 8'h00, {6'h00, level});
		reset = 1'b0;
		t_supply(8'h18, 5'h0F, 3'b110);
		t_refuse();
		t_supply(8'h80, 5'h00, 3'b011);
		t_req();
		t_trip(2'h3, 8'h45);
		t_trip(2'h1, 8'h25);
		t_trip(2'h2, 8'h35);
		t_supply(8'h18, 5'h0F, 3'b110);
		t_supply(8'h00, 5'h1F, 3'b100);
		wrap_up();
	end
endmodule
`default_nettype wire
